/* rtl/adc_conversion_sequencer.sv */
// Conversion sequencer: mode control, simultaneous hold, autoscan, eight-stage
// pipeline, internal oscillator, trigger counting and the samples-ready pin.
// Assumes digitised input words on the clk domain and a raw conversion pin.
`timescale 1ns/100ps
module adc_conversion_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic conv_pin,
  input wire logic [9:0] control_word0,
  input wire logic [3:0] chan_enable,
  input wire logic [1:0] diff_pair,
  input wire logic ref_external,
  input wire logic [3:0] trigger_level_count,
  input wire logic ready_active_high,
  input wire logic ready_pulse,
  input wire logic fifo_reset,
  input wire logic [9:0] sample_in0,
  input wire logic [9:0] sample_in1,
  input wire logic [9:0] sample_in2,
  input wire logic [9:0] sample_in3,
  input wire logic result_ready,
  output logic result_valid,
  output logic [9:0] result_data,
  output logic [1:0] result_chan,
  output logic samples_ready,
  output logic osc_running,
  output logic hold_active,
  output logic ref_external_sel,
  output logic seq_busy,
  output logic overrun
);

  localparam int DW = adc_seq_pkg::DATA_W;
  localparam int CW = adc_seq_pkg::CH_W;

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ----------------------------------------------------------------
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic pin_level_r;
  logic pin_fall;
  logic pin_rise;

  // Three stages; a change is accepted only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
      pin_level_r <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_s1_r <= conv_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r)
        pin_level_r <= pin_s3_r;
    end
  end

  assign pin_fall = pin_level_r && (pin_s2_r == pin_s3_r) && !pin_s3_r;
  assign pin_rise = !pin_level_r && (pin_s2_r == pin_s3_r) && pin_s3_r;

  // ----------------------------------------------------------------
  // Configuration capture
  // ----------------------------------------------------------------
  logic mode_single_r;
  logic [3:0] slot_en;
  logic [9:0] slot_val [adc_seq_pkg::NUM_IN];

  // Mode change takes effect one cycle after the register value settles
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_single_r <= 1'b0;
      ref_external_sel <= 1'b0;
    end
    else if (clk_en)
    begin
      mode_single_r <= control_word0[adc_seq_pkg::MODE_BIT];
      ref_external_sel <= ref_external;
    end
  end

  // A pair partner slot drops out so the pair scans as one channel
  assign slot_en[0] = chan_enable[0];
  assign slot_en[1] = chan_enable[1] && !diff_pair[0];
  assign slot_en[2] = chan_enable[2];
  assign slot_en[3] = chan_enable[3] && !diff_pair[1];

  // Differential value is centred on mid-scale
  function automatic logic [9:0] pair_code(input logic [9:0] p, input logic [9:0] m);
    logic [10:0] sum;
    sum = {1'b0, p} - {1'b0, m} + adc_seq_pkg::DIFF_OFFSET;
    return sum[10:1];
  endfunction

  assign slot_val[0] = diff_pair[0] ? pair_code(sample_in0, sample_in1) : sample_in0;
  assign slot_val[1] = sample_in1;
  assign slot_val[2] = diff_pair[1] ? pair_code(sample_in2, sample_in3) : sample_in2;
  assign slot_val[3] = sample_in3;

  // Next enabled slot after cur, wrapping; autoscan order is ascending
  function automatic logic [1:0] next_slot(input logic [1:0] cur, input logic [3:0] en);
    logic [1:0] pick;
    logic found;
    logic [1:0] cand;
    pick = cur;
    found = 1'b0;
    for (int i = 1; i <= adc_seq_pkg::NUM_IN; i++)
    begin
      cand = 2'(cur + 2'(i));
      if (!found && en[cand])
      begin
        pick = cand;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  function automatic logic [2:0] count_en(input logic [3:0] en);
    return 3'(en[0]) + 3'(en[1]) + 3'(en[2]) + 3'(en[3]);
  endfunction

  // ----------------------------------------------------------------
  // Single-shot sequencer and internal oscillator
  // ----------------------------------------------------------------
  adc_seq_pkg::seq_state_e state_r;
  logic [9:0] held_r [adc_seq_pkg::NUM_IN];
  logic [CW-1:0] slot_r;
  logic [2:0] left_r;
  logic [3:0] osc_cnt_r;
  logic osc_tick;
  logic pipe_empty;
  logic start_ok;
  logic feed_ok;

  assign osc_tick = osc_running && (osc_cnt_r == adc_seq_pkg::OSC_LAST);
  // A new start is taken only from idle with at least one channel
  assign start_ok = mode_single_r && pin_fall && (state_r == adc_seq_pkg::SEQ_IDLE)
                    && (slot_en != 4'h0);

  // Oscillator runs only while a single-shot sequence is active
  always_ff @(posedge clk)
  begin
    if (!rst_n || (clk_en && fifo_reset))
    begin
      osc_cnt_r <= adc_seq_pkg::CNT_RST;
      osc_running <= 1'b0;
    end
    else if (clk_en)
    begin
      osc_running <= mode_single_r && (start_ok || (state_r != adc_seq_pkg::SEQ_IDLE
                     && !(state_r == adc_seq_pkg::SEQ_FLUSH && pipe_empty)));
      if (!osc_running || osc_tick)
        osc_cnt_r <= adc_seq_pkg::CNT_RST;
      else
        osc_cnt_r <= osc_cnt_r + 4'h1;
    end
  end

  // Feed one held channel per oscillator period, then drain the pipeline
  always_ff @(posedge clk)
  begin
    if (!rst_n || (clk_en && fifo_reset))
    begin
      state_r <= adc_seq_pkg::SEQ_IDLE;
      slot_r <= adc_seq_pkg::SLOT_RST;
      left_r <= 3'h0;
      hold_active <= 1'b0;
      seq_busy <= 1'b0;
      for (int k = 0; k < adc_seq_pkg::NUM_IN; k++)
        held_r[k] <= '0;
    end
    else if (clk_en)
    begin
      unique case (state_r)
        adc_seq_pkg::SEQ_IDLE:
        begin
          if (start_ok)
          begin
            for (int k = 0; k < adc_seq_pkg::NUM_IN; k++)
              held_r[k] <= slot_val[k];
            slot_r <= next_slot(adc_seq_pkg::SLOT_RST, slot_en);
            left_r <= count_en(slot_en);
            hold_active <= 1'b1;
            seq_busy <= 1'b1;
            state_r <= adc_seq_pkg::SEQ_FEED;
          end
        end
        adc_seq_pkg::SEQ_FEED:
        begin
          if (osc_tick && feed_ok)
          begin
            slot_r <= next_slot(slot_r, slot_en);
            left_r <= left_r - 3'h1;
            if (left_r == 3'h1)
            begin
              hold_active <= 1'b0;
              state_r <= adc_seq_pkg::SEQ_FLUSH;
            end
          end
        end
        adc_seq_pkg::SEQ_FLUSH:
        begin
          if (pipe_empty)
          begin
            seq_busy <= 1'b0;
            state_r <= adc_seq_pkg::SEQ_IDLE;
          end
        end
        default:
          state_r <= adc_seq_pkg::SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Eight-stage pipeline
  // ----------------------------------------------------------------
  logic [DW-1:0] res_r [adc_seq_pkg::STAGES];
  logic [DW-1:0] code_r [adc_seq_pkg::STAGES];
  logic [CW-1:0] ch_r [adc_seq_pkg::STAGES];
  logic vld_r [adc_seq_pkg::STAGES];
  logic [DW-1:0] stage_mask [adc_seq_pkg::STAGES];
  logic last_vld;
  logic buf_in_ready;
  logic advance;
  logic [CW-1:0] scan_slot_r;
  logic feed_vld;
  logic [DW-1:0] feed_val;
  logic [CW-1:0] feed_ch;
  logic wr_en;
  logic cont_fall;

  assign last_vld = vld_r[adc_seq_pkg::STAGES-1];
  // Stall the pipeline rather than overwrite an unwritten result
  assign feed_ok = !last_vld || buf_in_ready;
  assign cont_fall = !mode_single_r && pin_fall && (slot_en != 4'h0);
  assign advance = (cont_fall && !last_vld) || (osc_tick && feed_ok);
  assign feed_vld = mode_single_r ? (state_r == adc_seq_pkg::SEQ_FEED) : 1'b1;
  // Continuous mode samples the live input of the next slot in the autoscan order
  assign feed_val = mode_single_r ? held_r[slot_r] : slot_val[next_slot(scan_slot_r, slot_en)];
  assign feed_ch = mode_single_r ? slot_r : next_slot(scan_slot_r, slot_en);
  // Single-shot writes as the last stage shifts out; continuous on the rising edge
  assign wr_en = last_vld && buf_in_ready && (mode_single_r ? osc_tick : pin_rise);

  genvar g;
  generate
    for (g = 0; g < adc_seq_pkg::STAGES; g++)
    begin : g_stage
      // Index of the stage in front; stage zero points at itself to stay in range
      localparam int PREV = (g == 0) ? 0 : g - 1;

      // One-bit stages resolve bits 9..6, two-bit stages 4 to 6 pairs of 5..0; stage 7 resolves none
      if (g < adc_seq_pkg::ONE_BIT_STAGES)
      begin : g_one
        assign stage_mask[g] = DW'(10'h200 >> g);
      end
      else
      begin : g_two
        assign stage_mask[g] = DW'(10'h030 >> (2 * (g - adc_seq_pkg::ONE_BIT_STAGES)));
      end

      // Each stage keeps its own sample so all eight work at once
      always_ff @(posedge clk)
      begin
        if (!rst_n || (clk_en && fifo_reset))
        begin
          res_r[g] <= '0;
          code_r[g] <= '0;
          ch_r[g] <= '0;
          vld_r[g] <= 1'b0;
        end
        else if (clk_en)
        begin
          if (advance)
          begin
            if (g == 0)
            begin
              res_r[g] <= feed_val;
              code_r[g] <= feed_val & stage_mask[g];
              ch_r[g] <= feed_ch;
              vld_r[g] <= feed_vld;
            end
            else
            begin
              res_r[g] <= res_r[PREV];
              code_r[g] <= code_r[PREV] | (res_r[PREV] & stage_mask[g]);
              ch_r[g] <= ch_r[PREV];
              vld_r[g] <= vld_r[PREV];
            end
          end
          else if (g == adc_seq_pkg::STAGES - 1 && wr_en)
            vld_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pipe_empty = !(vld_r[0] || vld_r[1] || vld_r[2] || vld_r[3]
                      || vld_r[4] || vld_r[5] || vld_r[6] || vld_r[7]);

  // Lost conversions are reported, sticky until FIFO reset
  always_ff @(posedge clk)
  begin
    if (!rst_n || (clk_en && fifo_reset))
      overrun <= 1'b0;
    else if (clk_en && cont_fall && last_vld)
      overrun <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  logic [adc_seq_pkg::BUF_W-1:0] buf_out;

  result_buffer #(
    .W(adc_seq_pkg::BUF_W)
  ) u_result_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .flush(fifo_reset),
    .in_valid(wr_en),
    .in_ready(buf_in_ready),
    .in_data({ch_r[adc_seq_pkg::STAGES-1], code_r[adc_seq_pkg::STAGES-1]}),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(buf_out)
  );

  assign result_data = buf_out[adc_seq_pkg::FLD_DATA_LSB +: DW];
  assign result_chan = buf_out[adc_seq_pkg::FLD_CHAN_LSB +: CW];

  // ----------------------------------------------------------------
  // Trigger counting and samples-ready pin
  // ----------------------------------------------------------------
  logic [3:0] wr_cnt_r;
  logic [3:0] rd_cnt_r;
  logic trig_hit;
  logic ready_lvl_r;
  logic ready_pls_r;
  logic rd_take;

  // Pipeline latency alone gives the seven-cycle lag after a FIFO reset
  assign trig_hit = wr_en && (4'(wr_cnt_r + 4'h1) == trigger_level_count);
  assign rd_take = result_valid && result_ready;

  always_ff @(posedge clk)
  begin
    if (!rst_n || (clk_en && fifo_reset))
      wr_cnt_r <= adc_seq_pkg::CNT_RST;
    else if (clk_en && wr_en)
      wr_cnt_r <= trig_hit ? adc_seq_pkg::CNT_RST : 4'(wr_cnt_r + 4'h1);
  end

  // Level mode holds until one block of trigger size is read; set beats clear
  always_ff @(posedge clk)
  begin
    if (!rst_n || (clk_en && fifo_reset))
    begin
      rd_cnt_r <= adc_seq_pkg::CNT_RST;
      ready_lvl_r <= 1'b0;
      ready_pls_r <= 1'b0;
    end
    else if (clk_en)
    begin
      ready_pls_r <= trig_hit;
      if (rd_take)
        rd_cnt_r <= (4'(rd_cnt_r + 4'h1) == trigger_level_count) ? adc_seq_pkg::CNT_RST
                    : 4'(rd_cnt_r + 4'h1);
      if (trig_hit)
        ready_lvl_r <= 1'b1;
      else if (rd_take && 4'(rd_cnt_r + 4'h1) == trigger_level_count)
        ready_lvl_r <= 1'b0;
    end
  end

  // Output polarity applied in a final flop so the pin is glitch-free
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      samples_ready <= 1'b0;
    else if (clk_en)
      samples_ready <= (ready_pulse ? ready_pls_r : ready_lvl_r) ~^ ready_active_high;
  end

  // Continuous scan pointer walks on each accepted falling edge; skipped edges leave it
  always_ff @(posedge clk)
  begin
    if (!rst_n || (clk_en && fifo_reset))
      scan_slot_r <= adc_seq_pkg::SLOT_RST;
    else if (clk_en && cont_fall && !last_vld)
      scan_slot_r <= next_slot(scan_slot_r, slot_en);
  end

endmodule // adc_conversion_sequencer

/* rtl/adc_seq_pkg.sv */
// Constants shared by the conversion sequencer and its output buffer.
// Assumes a single 40 MHz system clock; all counts are in its cycles.
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and internal oscillator timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  // Internal conversion period; plain default, trimmed per process
  localparam int OSC_PERIOD_NS = 200;
  // Least period rounds up, never below one cycle
  localparam int OSC_CYCLES_RAW = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_CYCLES = (OSC_CYCLES_RAW < 1) ? 1 : OSC_CYCLES_RAW;
  localparam logic [3:0] OSC_LAST = 4'(OSC_CYCLES - 1);

  // ----------------------------------------------------------------
  // Converter geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 10;
  localparam int NUM_IN = 4;
  localparam int CH_W = 2;
  localparam int ONE_BIT_STAGES = 4;
  localparam int TWO_BIT_STAGES = 4;
  localparam int STAGES = ONE_BIT_STAGES + TWO_BIT_STAGES;
  localparam int BUF_W = DATA_W + CH_W;
  localparam int BUF_DEPTH = 2;

  // Field positions inside a buffered word
  localparam int FLD_DATA_LSB = 0;
  localparam int FLD_CHAN_LSB = DATA_W;

  // Offset used to centre a differential result on mid-scale
  localparam logic [DATA_W:0] DIFF_OFFSET = 11'h400;

  // Control register 0 mode select position
  localparam int MODE_BIT = 1;

  // Reset values
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [CH_W-1:0] SLOT_RST = 2'h3;

  // ----------------------------------------------------------------
  // Single-shot sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FEED = 2'b01,
    SEQ_FLUSH = 2'b10
  } seq_state_e;

endpackage

/* rtl/result_buffer.sv */
// Two-entry valid/ready buffer between the converter pipeline and the reader.
// Assumes the writer honours in_ready; flush drops both entries at once.
`timescale 1ns/100ps
module result_buffer #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] head_r;
  logic [W-1:0] tail_r;
  logic head_vld_r;
  logic tail_vld_r;
  logic push;
  logic pop;

  // Ready depends only on the tail flop, so no path from the reader
  assign in_ready = !tail_vld_r;
  assign push = in_valid && in_ready;
  assign pop = head_vld_r && out_ready;
  assign out_valid = head_vld_r;
  assign out_data = head_r;

  // Head is the word on show, tail catches the word that arrives during a stall
  always_ff @(posedge clk)
  begin
    if (!rst_n || (clk_en && flush))
    begin
      head_r <= '0;
      tail_r <= '0;
      head_vld_r <= 1'b0;
      tail_vld_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (pop)
      begin
        if (tail_vld_r)
        begin
          head_r <= tail_r;
          head_vld_r <= 1'b1;
          tail_vld_r <= 1'b0;
        end
        else
        begin
          head_r <= in_data;
          head_vld_r <= push;
        end
      end
      else if (push)
      begin
        if (!head_vld_r)
        begin
          head_r <= in_data;
          head_vld_r <= 1'b1;
        end
        else
        begin
          tail_r <= in_data;
          tail_vld_r <= 1'b1;
        end
      end
    end
  end

endmodule // result_buffer

/* verif/adc_seq_chk_asserts.sv */
// Port checker for the conversion sequencer, bound to its top module.
// Assumes clk_en stays high; mode and polarity change only while idle.
`timescale 1ns/100ps
module adc_seq_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] control_word0,
  input wire logic ref_external,
  input wire logic ready_active_high,
  input wire logic ready_pulse,
  input wire logic fifo_reset,
  input wire logic result_ready,
  input wire logic result_valid,
  input wire logic [9:0] result_data,
  input wire logic [1:0] result_chan,
  input wire logic samples_ready,
  input wire logic osc_running,
  input wire logic hold_active,
  input wire logic ref_external_sel,
  input wire logic seq_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic act;
  // Ready pin at its active level for the chosen polarity
  assign act = samples_ready == ready_active_high;

  a_osc_off_cont: assert property (!control_word0[1] && !$past(control_word0[1], 2) |-> !osc_running)
    else $error("oscillator running in continuous mode");
  a_hold_in_busy: assert property (hold_active |-> seq_busy)
    else $error("hold outside a sequence");
  a_busy_osc_on: assert property (seq_busy |-> osc_running)
    else $error("sequence without oscillator");
  a_start_together: assert property ($rose(seq_busy) |-> hold_active && osc_running && $past(control_word0[1]))
    else $error("start did not raise hold and oscillator together");
  a_start_ignored: assert property ($rose(hold_active) |-> !$past(seq_busy))
    else $error("start taken during a running sequence");
  a_ref_follow: assert property ($past(rst_n) |-> ref_external_sel == $past(ref_external))
    else $error("reference select does not follow its setting");
  a_word_holds: assert property (result_valid && !result_ready && !fifo_reset |=> result_valid && $stable(result_data) && $stable(result_chan))
    else $error("result word lost under stall");
  a_reset_quiet: assert property (fifo_reset && $stable(ready_active_high) |-> ##2 !act [*2])
    else $error("ready active right after buffer reset");
  a_pulse_single: assert property (ready_pulse && $past(ready_pulse) && $stable(ready_active_high) && act |=> !act)
    else $error("ready pulse longer than one cycle");

  c_single: cover property ($rose(seq_busy));
  c_ready: cover property ($rose(act));
  c_stall: cover property (result_valid && !result_ready);
endmodule // adc_seq_chk

bind adc_conversion_sequencer adc_seq_chk u_adc_seq_chk (.clk(clk), .rst_n(rst_n),
  .control_word0(control_word0), .ref_external(ref_external),
  .ready_active_high(ready_active_high), .ready_pulse(ready_pulse), .fifo_reset(fifo_reset),
  .result_ready(result_ready), .result_valid(result_valid), .result_data(result_data),
  .result_chan(result_chan), .samples_ready(samples_ready), .osc_running(osc_running),
  .hold_active(hold_active), .ref_external_sel(ref_external_sel), .seq_busy(seq_busy));

/* verif/result_reader.sv */
// Reader model: the processor side taking result words.
// Assumes the bench sets stall_pct between 0 and 99.
`timescale 1ns/100ps
module result_reader (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] stall_pct,
  output logic result_ready
);
  // Ready drops at random so the two-entry buffer must hold words
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      result_ready <= 1'b0;
    else
      result_ready <= ($urandom % 100) >= stall_pct;
  end
endmodule // result_reader

/* verif/tb_adc_conversion_sequencer.sv */
// Testbench for the conversion sequencer: single-shot and continuous runs.
// Assumes the reader model and the bound checker beside it.
`timescale 1ns/100ps
module tb_adc_conversion_sequencer;
  logic clk, rst_n, conv_pin, ref_external, ready_active_high, ready_pulse, fifo_reset;
  logic [9:0] control_word0, result_data;
  logic [3:0] chan_enable, trigger_level_count;
  logic [1:0] diff_pair, result_chan;
  logic [9:0] smp [4];
  logic result_ready, result_valid, samples_ready, osc_running, hold_active;
  logic ref_external_sel, seq_busy, overrun, act;
  logic [6:0] stall_pct;
  logic [5:0] cfg;
  logic [11:0] got [$];
  logic [11:0] ex [$];
  int failures, n_tests, cycles, act_cnt;

  adc_conversion_sequencer u_adc_conversion_sequencer (.clk(clk), .rst_n(rst_n),
    .clk_en(1'b1), .conv_pin(conv_pin), .control_word0(control_word0),
    .chan_enable(chan_enable), .diff_pair(diff_pair), .ref_external(ref_external),
    .trigger_level_count(trigger_level_count), .ready_active_high(ready_active_high),
    .ready_pulse(ready_pulse), .fifo_reset(fifo_reset), .sample_in0(smp[0]),
    .sample_in1(smp[1]), .sample_in2(smp[2]), .sample_in3(smp[3]),
    .result_ready(result_ready), .result_valid(result_valid), .result_data(result_data),
    .result_chan(result_chan), .samples_ready(samples_ready), .osc_running(osc_running),
    .hold_active(hold_active), .ref_external_sel(ref_external_sel), .seq_busy(seq_busy),
    .overrun(overrun));
  result_reader u_result_reader (.clk(clk), .rst_n(rst_n), .stall_pct(stall_pct),
    .result_ready(result_ready));

  assign act = samples_ready === ready_active_high;

  // ----------
  // Helpers
  // ----------
  task automatic chk(input string nm, input logic [11:0] g, input logic [11:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A paired input counts once, under its lower slot
  function automatic logic on(input int s);
    return chan_enable[s] && !(s % 2 == 1 && diff_pair[s / 2]);
  endfunction

  function automatic logic [11:0] word_for(input int s);
    logic [10:0] d;
    d = {1'b0, smp[s]};
    if (diff_pair[s / 2])
      d = ({1'b0, smp[s]} - {1'b0, smp[s + 1]} + 11'h400) >> 1;
    return {2'(s), d[9:0]};
  endfunction

  // Expected words in scan order; returns channel count
  function automatic int build();
    ex.delete();
    for (int s = 0; s < 4; s++)
      if (on(s))
        ex.push_back(word_for(s));
    return ex.size();
  endfunction

  // Random channel mix; a pair always has both inputs enabled
  task automatic setup(input logic [5:0] c);
    chan_enable <= (c[3:0] | {{2{c[5]}}, {2{c[4]}}}) | (c[3:0] == 4'h0 ? 4'h8 : 4'h0);
    diff_pair <= c[5:4];
    ref_external <= 1'($urandom);
    for (int s = 0; s < 4; s++)
      smp[s] <= 10'($urandom);
    cyc(2);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic single_run;
    int n, t;
    n = build();
    trigger_level_count <= 4'(n);
    control_word0 <= 10'h002;
    cyc(8);
    chk("ref_sel", 12'(ref_external_sel), 12'(ref_external));
    got.delete();
    act_cnt = 0;
    conv_pin <= 1'b0;
    t = 0;
    while (!hold_active && t < 20)
    begin
      cyc(1);
      t++;
    end
    for (int s = 0; s < 4; s++)
      smp[s] <= 10'($urandom);
    conv_pin <= 1'b1;
    cyc(3);
    conv_pin <= 1'b0;
    cyc(3);
    conv_pin <= 1'b1;
    t += 6;
    while (act_cnt == 0 && t < 400)
    begin
      cyc(1);
      t++;
    end
    chk("ready_delay", 12'(t >= (6 + n) * 8 && t <= (8 + n) * 8 + 10), 12'h001);
    while ((seq_busy || result_valid) && t < 800)
    begin
      cyc(1);
      t++;
    end
    cyc(4);
    chk("word_count", 12'(got.size()), 12'(n));
    for (int i = 0; i < n && i < got.size(); i++)
      chk("held_word", got[i], ex[i]);
    if (ready_pulse)
      chk("pulse_len", 12'(act_cnt), 12'h001);
    chk("ready_after_read", 12'(act), 12'h000);
    cyc(40);
  endtask

  task automatic cont_run;
    int n, first;
    n = build();
    control_word0 <= 10'h000;
    trigger_level_count <= 4'(n);
    cyc(4);
    fifo_reset <= 1'b1;
    cyc(1);
    fifo_reset <= 1'b0;
    got.delete();
    act_cnt = 0;
    first = 0;
    // Sixteen-cycle conversion clock keeps the total rate within limits
    for (int k = 1; k <= 40; k++)
    begin
      conv_pin <= 1'b0;
      cyc(8);
      conv_pin <= 1'b1;
      cyc(8);
      if (act_cnt > 0 && first == 0)
        first = k;
    end
    cyc(30);
    chk("first_ready", 12'(first >= 7 + n && first <= 8 + n), 12'h001);
    chk("cont_words", 12'(got.size() >= 32 && got.size() <= 33), 12'h001);
    chk("overrun", 12'(overrun), 12'h000);
    chk("osc_off", 12'(osc_running), 12'h000);
    for (int i = 0; i < got.size(); i++)
      chk("scan_word", got[i], ex[i % n]);
  endtask

  // ----------
  // Clock, monitor, watchdog
  // ----------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Words taken by the reader, and cycles with ready active
  always @(posedge clk)
  begin
    cycles++;
    if (rst_n && result_valid === 1'b1 && result_ready === 1'b1)
      got.push_back({result_chan, result_data});
    if (act)
      act_cnt++;
    if (cycles == 30000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    conv_pin = 1'b1;
    control_word0 = 10'h002;
    chan_enable = 4'h1;
    diff_pair = 2'h0;
    ref_external = 1'b0;
    trigger_level_count = 4'h1;
    ready_active_high = 1'b1;
    ready_pulse = 1'b0;
    fifo_reset = 1'b0;
    stall_pct = 7'd30;
    for (int s = 0; s < 4; s++)
      smp[s] = 10'h000;
    void'($urandom(32'hC4E6));
    cyc(10);
    chk("reset_outs", 12'({result_valid, osc_running, hold_active, seq_busy, overrun}), 12'h000);
    cyc(10);
    rst_n <= 1'b1;
    cyc(6);
    // Every polarity and pulse choice, then random mixes
    for (int i = 0; i < 8; i++)
    begin
      ready_active_high <= 1'(i);
      ready_pulse <= 1'(i >> 1);
      cfg = i == 0 ? 6'h0F : (i == 1 ? 6'h3F : (i == 2 ? 6'h1C : 6'($urandom)));
      setup(cfg);
      single_run();
    end
    setup(6'h0F);
    cont_run();
    setup(6'h1C);
    cont_run();
    close_out();
  end
endmodule // tb_adc_conversion_sequencer
